// ===== hw/pfg_pkg.sv
// Behaviour
// - every YUV window line holds an even number of pixels, so the device only ever completes whole pairs.
// - luma and chroma are taken as BT601 samples when they are converted to RGB.
// - a 4:2:0 odd line starts with one U and an even line with one V, then luma only, and the device tracks which.
// - table loading selects access mode, writes the index once, then streams data with auto-increment, then enables.
// - the odd pixel of a pair sits on the upper half, red on the top six lines, msb highest.
// - the odd pixel's green sits on the next six lines and its blue on the six below, msb highest.
// - the even pixel sits on the lower half in the same cycle, red on the top six lower lines, msb highest.
// - the even pixel's green is below its red, its blue on the lowest six lines, and cycles carry successive pairs.
package pfg_pkg;
	localparam int SAMPLE_W = 8;
	localparam int COMP_W = 6;
	localparam int LUT_DEPTH = 64;
	localparam int LUT_IDX_W = 6;
	localparam int LUT_DATA_W = 8;
	localparam int LINE_W = 11;
	localparam int BUF_DEPTH = 2;
	localparam logic [LINE_W-1:0] PIX_CNT_RST = 11'h000;
	localparam logic [LINE_W-1:0] PAIR_STEP = 11'h002;
	localparam logic [LUT_IDX_W-1:0] LUT_IDX_RST = 6'h00;
	localparam logic [1:0] LUT_SEL_R = 2'h0;
	localparam logic [1:0] LUT_SEL_G = 2'h1;
	localparam logic [1:0] LUT_SEL_B = 2'h2;
	// bt601 integer coefficients, scaled by 256
	localparam logic signed [19:0] Y_OFS = 20'sh00010;
	localparam logic signed [19:0] C_OFS = 20'sh00080;
	localparam logic signed [19:0] K_Y = 20'sh0012a;
	localparam logic signed [19:0] K_RV = 20'sh00199;
	localparam logic signed [19:0] K_GU = 20'sh00064;
	localparam logic signed [19:0] K_GV = 20'sh000d0;
	localparam logic signed [19:0] K_BU = 20'sh00204;
	localparam logic signed [19:0] ROUND = 20'sh00080;
	localparam logic signed [19:0] MAX_8 = 20'sh000ff;

	typedef enum logic [1:0] {
		ST_CB,
		ST_YA,
		ST_CR,
		ST_YB
	} pfg_state_e;

	typedef struct packed {
		logic [COMP_W-1:0] r;
		logic [COMP_W-1:0] g;
		logic [COMP_W-1:0] b;
	} pfg_pix_s;

	// upper half carries the odd (second) pixel
	typedef struct packed {
		pfg_pix_s odd;
		pfg_pix_s even;
	} pfg_pair_s;

	function automatic logic [COMP_W-1:0] pfg_clip(input logic signed [19:0] x);
		logic signed [19:0] s;
		s = x >>> 8;
		if (s < 0) begin
			return '0;
		end else if (s > MAX_8) begin
			return '1;
		end
		return s[7:2];
	endfunction

	function automatic pfg_pix_s pfg_yuv2rgb(input logic [7:0] y, input logic [7:0] u, input logic [7:0] v);
		logic signed [19:0] c;
		logic signed [19:0] d;
		logic signed [19:0] e;
		pfg_pix_s p;
		c = $signed({12'h000, y}) - Y_OFS;
		d = $signed({12'h000, u}) - C_OFS;
		e = $signed({12'h000, v}) - C_OFS;
		p.r = pfg_clip(K_Y * c + K_RV * e + ROUND);
		p.g = pfg_clip(K_Y * c - K_GU * d - K_GV * e + ROUND);
		p.b = pfg_clip(K_Y * c + K_BU * d + ROUND);
		return p;
	endfunction
endpackage

// ===== hw/pfg_top.sv
`timescale 1ns/1ps
`default_nettype none
module pfg_top
	import pfg_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic win_start_i,
	input wire logic fmt_420_i,
	input wire logic [LINE_W-1:0] line_len_i,
	input wire logic [SAMPLE_W-1:0] yuv_data_i,
	input wire logic yuv_valid_i,
	output logic yuv_ready_o,
	input wire logic lut_access_i,
	input wire logic [1:0] lut_sel_i,
	input wire logic lut_idx_wr_i,
	input wire logic lut_data_wr_i,
	input wire logic [LUT_DATA_W-1:0] lut_wdata_i,
	input wire logic gamma_en_i,
	output logic [35:0] panel_pixel_bus_o,
	output logic panel_valid_o,
	input wire logic panel_ready_i
);
	logic rst_meta_q;
	logic rst_n;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	pfg_state_e state_q;
	pfg_state_e state_d;
	logic odd_line_q;
	logic [LINE_W-1:0] pix_cnt_q;
	logic [SAMPLE_W-1:0] u_q;
	logic [SAMPLE_W-1:0] v_q;
	logic [SAMPLE_W-1:0] ya_q;
	logic [LUT_IDX_W-1:0] lut_idx_q;
	logic [$clog2(BUF_DEPTH+1)-1:0] cnt_q;
	logic rd_ptr_q;
	logic wr_ptr_q;
	pfg_pair_s buf_q [0:BUF_DEPTH-1];

	wire buf_full = (cnt_q == 2'(BUF_DEPTH));
	wire take = yuv_valid_i && yuv_ready_o;
	wire take_cb = take && (state_q == ST_CB);
	wire take_cr = take && (state_q == ST_CR);
	wire take_ya = take && (state_q == ST_YA);
	wire take_yb = take && (state_q == ST_YB);
	wire [LINE_W-1:0] pix_next = pix_cnt_q + PAIR_STEP;
	// pairs only, so the line ends exactly on a second luma
	wire line_end = fmt_420_i && (pix_next >= line_len_i);
	wire pop = panel_valid_o && panel_ready_i;
	wire push = take_yb;

	// a full buffer halts the sample stream, so no pair is ever dropped
	assign yuv_ready_o = !buf_full && !win_start_i;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_CB: begin
				if (take_cb) begin
					state_d = ST_YA;
				end
			end
			ST_CR: begin
				if (take_cr) begin
					// 4:2:2 puts the second luma after v; 4:2:0 lines carry luma only after their chroma
					state_d = fmt_420_i ? ST_YA : ST_YB;
				end
			end
			ST_YA: begin
				if (take_ya) begin
					state_d = fmt_420_i ? ST_YB : ST_CR;
				end
			end
			ST_YB: begin
				if (take_yb) begin
					if (!fmt_420_i) begin
						state_d = ST_CB;
					end else if (line_end) begin
						state_d = odd_line_q ? ST_CR : ST_CB;
					end else begin
						state_d = ST_YA;
					end
				end
			end
			default: state_d = ST_CB;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_CB;
			odd_line_q <= 1'b1;
			pix_cnt_q <= PIX_CNT_RST;
		end else if (win_start_i) begin
			state_q <= ST_CB;
			odd_line_q <= 1'b1;
			pix_cnt_q <= PIX_CNT_RST;
		end else begin
			state_q <= state_d;
			if (take_yb && line_end) begin
				odd_line_q <= !odd_line_q;
				pix_cnt_q <= PIX_CNT_RST;
			end else if (take_yb) begin
				pix_cnt_q <= pix_next;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			u_q <= '0;
			v_q <= '0;
			ya_q <= '0;
		end else begin
			if (take_cb) begin
				u_q <= yuv_data_i;
			end
			if (take_cr) begin
				v_q <= yuv_data_i;
			end
			if (take_ya) begin
				ya_q <= yuv_data_i;
			end
		end
	end

	// both pixels of a pair share the held chroma
	pfg_pix_s rgb_even;
	pfg_pix_s rgb_odd;
	assign rgb_even = pfg_yuv2rgb(ya_q, u_q, v_q);
	assign rgb_odd = pfg_yuv2rgb(yuv_data_i, u_q, v_q);

	// gamma tables on the display side; lookups use the top six bits of each entry
	wire lut_wr = lut_access_i && lut_data_wr_i;
	logic [COMP_W-1:0] gam_even [0:2];
	logic [COMP_W-1:0] gam_odd [0:2];
	wire [COMP_W-1:0] raw_even [0:2] = '{rgb_even.r, rgb_even.g, rgb_even.b};
	wire [COMP_W-1:0] raw_odd [0:2] = '{rgb_odd.r, rgb_odd.g, rgb_odd.b};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_lut
			logic [LUT_DATA_W-1:0] tbl_q [0:LUT_DEPTH-1];
			wire sel = (lut_sel_i == 2'(gi));
			always_ff @(posedge sys_clk_i) begin
				if (lut_wr && sel) begin
					tbl_q[lut_idx_q] <= lut_wdata_i;
				end
			end
			wire [LUT_DATA_W-1:0] hit_even = tbl_q[raw_even[gi]];
			wire [LUT_DATA_W-1:0] hit_odd = tbl_q[raw_odd[gi]];
			// bypass while disabled; a table loaded while gamma_en_i is low reaches the panel once gamma_en_i goes high
			assign gam_even[gi] = gamma_en_i ? hit_even[7:2] : raw_even[gi];
			assign gam_odd[gi] = gamma_en_i ? hit_odd[7:2] : raw_odd[gi];
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lut_idx_q <= LUT_IDX_RST;
		end else if (lut_access_i && lut_idx_wr_i) begin
			lut_idx_q <= lut_wdata_i[LUT_IDX_W-1:0];
		end else if (lut_wr) begin
			lut_idx_q <= lut_idx_q + 6'h01;
		end
	end

	pfg_pair_s pair_in;
	// one driver for the whole pair
	assign pair_in = '{
		odd: '{r: gam_odd[0], g: gam_odd[1], b: gam_odd[2]},
		even: '{r: gam_even[0], g: gam_even[1], b: gam_even[2]}
	};

	// two-entry buffer between pair assembly and the panel
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			buf_q[wr_ptr_q] <= pair_in;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			rd_ptr_q <= 1'b0;
			wr_ptr_q <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_q <= !wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= !rd_ptr_q;
			end
			case ({push, pop})
				2'b10: cnt_q <= cnt_q + 2'h1;
				2'b01: cnt_q <= cnt_q - 2'h1;
				default: cnt_q <= cnt_q;
			endcase
		end
	end

	assign panel_valid_o = (cnt_q != 2'h0);
	// idle bus reads as zero rather than a stale pair
	assign panel_pixel_bus_o = panel_valid_o ? buf_q[rd_ptr_q] : 36'h000000000;
endmodule // pfg_top
`default_nettype wire

// ===== verification/pfg_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pfg_top_asserts (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic win_start_i,
	input wire logic fmt_420_i,
	input wire logic yuv_valid_i,
	input wire logic yuv_ready_o,
	input wire logic [35:0] panel_pixel_bus_o,
	input wire logic panel_valid_o,
	input wire logic panel_ready_i
);
	logic [1:0] ph_q;
	wire take = yuv_valid_i && yuv_ready_o;
	// sample phase inside a 4:2:2 pair
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) ph_q <= 2'h0;
		else if (win_start_i) ph_q <= 2'h0;
		else if (take) ph_q <= ph_q + 2'h1;
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_last; !fmt_420_i && take && ph_q == 2'h3; endsequence
	sequence s_stall; panel_valid_o && !panel_ready_i; endsequence
	property p_pair; s_last |=> panel_valid_o; endproperty
	a_pair: assert property (p_pair) else $error("no pair after fourth sample");
	property p_quiet; !fmt_420_i && !panel_valid_o && !(take && ph_q == 2'h3) |=> !panel_valid_o; endproperty
	a_quiet: assert property (p_quiet) else $error("pair shown early");
	property p_hold; s_stall |=> panel_valid_o && $stable(panel_pixel_bus_o); endproperty
	a_hold: assert property (p_hold) else $error("pair lost in stall");
	property p_zero; !panel_valid_o |-> panel_pixel_bus_o == 36'h0; endproperty
	a_zero: assert property (p_zero) else $error("bus not idle");
	property p_win; win_start_i |-> !yuv_ready_o; endproperty
	a_win: assert property (p_win) else $error("sample taken at window start");
	property p_full; !yuv_ready_o && !win_start_i |-> panel_valid_o; endproperty
	a_full: assert property (p_full) else $error("refused while empty");
	property p_next; panel_valid_o && panel_ready_i && !yuv_ready_o && !win_start_i |=> panel_valid_o; endproperty
	a_next: assert property (p_next) else $error("second pair not shown");
	property p_boot; $rose(rst_n_i) |-> !panel_valid_o [*3]; endproperty
	a_boot: assert property (p_boot) else $error("output after reset");
endmodule // pfg_top_asserts
bind pfg_top pfg_top_asserts u_chk (.sys_clk_i, .rst_n_i, .win_start_i, .fmt_420_i, .yuv_valid_i, .yuv_ready_o,
	.panel_pixel_bus_o, .panel_valid_o, .panel_ready_i);
`default_nettype wire

// ===== verification/pfg_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfg_panel_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic hold_i,
	input wire logic valid_i,
	input wire logic [35:0] bus_i,
	output logic ready_o
);
	logic [35:0] rx_q[$];
	// ready alternates so a pair shown while ready is low meets a stall
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) ready_o <= 1'b0;
		else begin
			ready_o <= !hold_i && !ready_o;
			if (valid_i && ready_o) rx_q.push_back(bus_i);
		end
	end
endmodule // pfg_panel_model
`default_nettype wire

// ===== verification/pfg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pfg_top_tb import pfg_pkg::*;;
	logic clk = 1'b0, rst_n = 1'b0, win, f420, yv, lacc, liw, ldw, gen, hold;
	logic [LINE_W-1:0] llen;
	logic [7:0] yd, lwd;
	logic [1:0] lsel;
	wire yr, pv, pr;
	wire [35:0] bus;
	int err_total = 0, n_checks = 0;
	always #12.5 clk = ~clk;
	pfg_top dut (.sys_clk_i(clk), .rst_n_i(rst_n), .win_start_i(win), .fmt_420_i(f420), .line_len_i(llen),
		.yuv_data_i(yd), .yuv_valid_i(yv), .yuv_ready_o(yr), .lut_access_i(lacc), .lut_sel_i(lsel),
		.lut_idx_wr_i(liw), .lut_data_wr_i(ldw), .lut_wdata_i(lwd), .gamma_en_i(gen),
		.panel_pixel_bus_o(bus), .panel_valid_o(pv), .panel_ready_i(pr));
	pfg_panel_model m (.clk_i(clk), .rst_n_i(rst_n), .hold_i(hold), .valid_i(pv), .bus_i(bus), .ready_o(pr));
	task stop_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(string nm, logic [35:0] got, logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s exp %h got %h", nm, exp, got);
		end
	endtask
	// valid stays up between samples; callers drop it after the last one
	task put(logic [7:0] b);
		int n;
		n = 0;
		yd <= b;
		yv <= 1'b1;
		@(negedge clk);
		while (yr !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (n >= 400) begin
			err_total++;
			stop_test;
		end
		@(posedge clk);
	endtask
	task pair(logic [7:0] u, y0, v, y1);
		put(u);
		put(y0);
		put(v);
		put(y1);
	endtask
	task expect_pair(string nm, logic [35:0] e);
		int n;
		n = 0;
		while (m.rx_q.size() == 0 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n >= 400) begin
			err_total++;
			stop_test;
		end
		chk(nm, m.rx_q.pop_front(), e);
	endtask
	task start(logic f);
		win <= 1'b1;
		yv <= 1'b0;
		f420 <= f;
		@(posedge clk);
		win <= 1'b0;
	endtask
	task t_reset;
		@(negedge clk);
		chk("ready", yr, 36'h1);
		chk("valid", pv, 36'h0);
		chk("bus", bus, 36'h0);
		@(posedge clk);
		$display("t_reset done");
	endtask
	task t_422;
		pair(8'h80, 8'h10, 8'hff, 8'h10);
		pair(8'h80, 8'h10, 8'h80, 8'heb);
		yv <= 1'b0;
		expect_pair("red", 36'hc80032000);
		expect_pair("gray", 36'hffffc0000);
		$display("t_422 done");
	endtask
	task t_full;
		hold <= 1'b1;
		pair(8'h80, 8'h10, 8'h80, 8'heb);
		pair(8'h80, 8'h10, 8'h80, 8'heb);
		yv <= 1'b0;
		repeat (2) @(negedge clk);
		chk("full", yr, 36'h0);
		@(posedge clk);
		hold <= 1'b0;
		expect_pair("q0", 36'hffffc0000);
		expect_pair("q1", 36'hffffc0000);
		$display("t_full done");
	endtask
	// four-pixel lines so the pair counter runs past its first pair
	task t_420;
		llen <= 11'h004;
		start(1'b1);
		put(8'hff);
		repeat (4) put(8'h10);
		// cut after the odd line: the next chroma must count as u again
		start(1'b1);
		put(8'h80);
		repeat (4) put(8'h10);
		put(8'hff);
		repeat (4) put(8'h10);
		yv <= 1'b0;
		expect_pair("odd", 36'h000fc003f);
		expect_pair("odd2", 36'h000fc003f);
		expect_pair("restart", 36'h0);
		expect_pair("restart2", 36'h0);
		expect_pair("even", 36'hc80032000);
		expect_pair("even2", 36'hc80032000);
		$display("t_420 done");
	endtask
	task t_gamma;
		start(1'b0);
		lacc <= 1'b1;
		lwd <= 8'h00;
		liw <= 1'b1;
		@(posedge clk);
		liw <= 1'b0;
		ldw <= 1'b1;
		for (int t = 0; t < 3; t++) for (int i = 0; i < 64; i++) begin
			lsel <= t[1:0];
			lwd <= (t == 0) ? 8'(i * 4) : (t == 1) ? 8'((63 - i) * 4) : 8'h54;
			@(posedge clk);
		end
		ldw <= 1'b0;
		lacc <= 1'b0;
		gen <= 1'b1;
		pair(8'h80, 8'h10, 8'h80, 8'heb);
		yv <= 1'b0;
		expect_pair("gamma", 36'hfc0540fd5);
		$display("t_gamma done");
	endtask
	initial begin
		{win, f420, yv, lacc, liw, ldw, gen, hold} = '0;
		llen = 11'h002;
		yd = 8'h00;
		lwd = 8'h00;
		lsel = 2'h3;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		t_422;
		t_full;
		t_420;
		t_gamma;
		stop_test;
	end
endmodule // pfg_top_tb
`default_nettype wire
